// >>> rlm_ctrl.sv
// Purpose: reset response and lock/free-run mode selection
// Assumes: pins are asynchronous and synchronised here; refLocked from the synthesiser
// Notes:   the board keeps reset low long enough; timing generation lives elsewhere
// Contract
// - scan select high means boundary-scan test mode, low means host mode.
// - host mode reset low returns registers and blocks to defaults.
// - host mode reset low tri-states all inputs and outputs except exceptions.
// - host mode reset low drives both single-ended pixel clocks low.
// - host mode reset release resumes operation from default settings.
// - scan mode reset low defaults blocks and holds the test sequence reset.
// - scan mode reset release lets the test sequence run again.
// - lock select low with reference locked enters locked mode.
// - locked mode keeps video clock and timing locked to reference.
// - lock select high lets video clock and timing generator free-run.
// - audio clocks follow the video clock whatever lock select is.
// - lock select low without reference outputs follow internal defaults.
// - crystal input also accepts an external 27 MHz clock.
`timescale 1ns/1ps
`default_nettype none

module rlm_sync #(
  parameter int unsigned STAGES = rlm_pkg::SYNC_STAGES,
  parameter logic        INIT   = 1'b0
) (
  input  wire logic mclk,
  input  wire logic reset_n,
  input  wire logic asyncIn,
  output logic      syncOut
);
  logic [STAGES-1:0] stage_r;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      stage_r <= {STAGES{INIT}};
    end else begin
      stage_r <= {stage_r[STAGES-2:0], asyncIn};
    end
  end

  assign syncOut = stage_r[STAGES-1];
endmodule : rlm_sync

module rlm_ctrl #(
  parameter int unsigned FILT_CYC = rlm_pkg::RELEASE_FILT_CYC
) (
  input  wire logic          mclk,
  input  wire logic          reset_n,
  input  wire logic          resetPinN,
  input  wire logic          lockSelN,
  input  wire logic          scanSel,
  input  wire logic          xtal_in,
  input  wire logic          refPresent,
  input  wire logic          refLocked,
  input  wire logic          pixelClkA,
  input  wire logic          pixelClkB,
  output logic               pixel_clk_out_a,
  output logic               pixel_clk_out_a_oe,
  output logic               pixel_clk_out_b,
  output logic               pixel_clk_out_b_oe,
  output logic               refClk,
  output rlm_pkg::rlm_ctl_t  ctl,
  output rlm_pkg::rlm_clk_t  clk,
  output rlm_pkg::rlm_state_t state
);
  localparam int unsigned CW = $clog2(FILT_CYC + 1);

  logic              resetSync;
  logic              lockSync;
  logic              scanSync;
  logic              resetPinN_r;
  logic              scanMode_r;
  logic [CW-1:0]     filt_r;
  logic [CW-1:0]     filtNxt;
  logic              released;
  rlm_pkg::rlm_state_t state_r;
  rlm_pkg::rlm_state_t stateNxt;
  rlm_pkg::rlm_ctl_t   ctl_r;
  rlm_pkg::rlm_ctl_t   ctlNxt;
  rlm_pkg::rlm_clk_t   clk_r;
  rlm_pkg::rlm_clk_t   clkNxt;

  rlm_sync #(.STAGES(rlm_pkg::SYNC_STAGES), .INIT(1'b0)) uRst (
    .mclk    (mclk),
    .reset_n (reset_n),
    .asyncIn (resetPinN),
    .syncOut (resetSync)
  );

  rlm_sync #(.STAGES(rlm_pkg::SYNC_STAGES), .INIT(1'b1)) uLock (
    .mclk    (mclk),
    .reset_n (reset_n),
    .asyncIn (lockSelN),
    .syncOut (lockSync)
  );

  rlm_sync #(.STAGES(rlm_pkg::SYNC_STAGES), .INIT(1'b0)) uScan (
    .mclk    (mclk),
    .reset_n (reset_n),
    .asyncIn (scanSel),
    .syncOut (scanSync)
  );

  // assertion of reset acts at once; release waits for sync and filter
  wire pinLow = !resetPinN || !resetPinN_r;
  wire filtDone = (filt_r == CW'(FILT_CYC));
  assign filtNxt = pinLow || !resetSync ? '0 : (filtDone ? filt_r : filt_r + 1'b1);
  assign released = filtDone && !pinLow;

  wire inScan = (scanMode_r == rlm_pkg::PIN_SCAN_SEL);
  wire wantLock = (lockSync == rlm_pkg::LOCK_SEL_LOW);

  always_comb begin
    stateNxt = state_r;
    unique case (state_r)
      rlm_pkg::RLM_ST_RESET: begin
        if (released) begin
          stateNxt = wantLock ? rlm_pkg::RLM_ST_SEEK : rlm_pkg::RLM_ST_FREE;
        end
      end
      rlm_pkg::RLM_ST_FREE: begin
        if (wantLock) begin
          stateNxt = rlm_pkg::RLM_ST_SEEK;
        end
      end
      rlm_pkg::RLM_ST_SEEK: begin
        if (!wantLock) begin
          stateNxt = rlm_pkg::RLM_ST_FREE;
        end else if (refPresent && refLocked) begin
          stateNxt = rlm_pkg::RLM_ST_LOCKED;
        end
      end
      rlm_pkg::RLM_ST_LOCKED: begin
        if (!wantLock) begin
          stateNxt = rlm_pkg::RLM_ST_FREE;
        end else if (!refPresent || !refLocked) begin
          stateNxt = rlm_pkg::RLM_ST_SEEK;
        end
      end
    endcase
    if (!released) begin
      stateNxt = rlm_pkg::RLM_ST_RESET;
    end
  end

  wire nxtRst = (stateNxt == rlm_pkg::RLM_ST_RESET);
  wire nxtLocked = (stateNxt == rlm_pkg::RLM_ST_LOCKED);
  wire nxtSeek = (stateNxt == rlm_pkg::RLM_ST_SEEK);

  always_comb begin
    ctlNxt.scanMode     = inScan;
    ctlNxt.blockRstN    = !nxtRst;
    ctlNxt.tapRstN      = !(nxtRst && inScan);
    ctlNxt.ioEnable     = inScan || !nxtRst;
    ctlNxt.pclkForceLow = nxtRst && !inScan;
    clkNxt.locked        = nxtLocked;
    clkNxt.followRef     = nxtLocked;
    clkNxt.useDefaults   = nxtSeek && !refPresent;
    clkNxt.freeRun       = !nxtLocked && !nxtSeek;
    clkNxt.audioFollowVid = 1'b1;
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      resetPinN_r <= 1'b0;
      scanMode_r  <= 1'b0;
      filt_r      <= '0;
      state_r     <= rlm_pkg::RLM_ST_RESET;
      ctl_r       <= '{blockRstN: 1'b0, tapRstN: 1'b0, ioEnable: 1'b0,
                       pclkForceLow: 1'b1, scanMode: 1'b0};
      clk_r       <= '{followRef: 1'b0, useDefaults: 1'b0, freeRun: 1'b1,
                       audioFollowVid: 1'b1, locked: 1'b0};
    end else begin
      resetPinN_r <= resetPinN;
      scanMode_r  <= scanSync;
      filt_r      <= filtNxt;
      state_r     <= stateNxt;
      ctl_r       <= ctlNxt;
      clk_r       <= clkNxt;
    end
  end

  // pixel clocks are driven low in host-mode reset, never floated
  assign pixel_clk_out_a    = ctl_r.pclkForceLow ? rlm_pkg::PCLK_RESET_LV : pixelClkA;
  assign pixel_clk_out_b    = ctl_r.pclkForceLow ? rlm_pkg::PCLK_RESET_LV : pixelClkB;
  assign pixel_clk_out_a_oe = 1'b1;
  assign pixel_clk_out_b_oe = 1'b1;

  // crystal pin doubles as a direct 27 MHz clock input
  assign refClk = xtal_in;

  assign ctl   = ctl_r;
  assign clk   = clk_r;
  assign state = state_r;
endmodule : rlm_ctrl

`default_nettype wire

// >>> rlm_pkg.sv
// Purpose: shared constants and carriers for reset and lock mode control
// Assumes: one clock domain, mclk at 100 MHz
// Notes:   pin groups travel as packed structs
package rlm_pkg;

  localparam int unsigned MCLK_HZ        = 100_000_000;
  localparam int unsigned MCLK_PERIOD_NS = 10;
  localparam int unsigned XTAL_REF_MHZ   = 27;
  localparam int unsigned XTAL_REF_HZ    = XTAL_REF_MHZ * 1_000_000;

  // least reset hold after supplies settle, in microseconds
  localparam int unsigned RESET_HOLD_US  = 500;
  localparam int unsigned RESET_HOLD_CYC =
    (RESET_HOLD_US * 1000 + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;

  // cycles of stable sync'd reset-high before release takes effect
  localparam int unsigned RELEASE_FILT_CYC = 2;
  localparam int unsigned SYNC_STAGES      = 2;

  localparam logic PIN_SCAN_SEL  = 1'b1;
  localparam logic LOCK_SEL_LOW  = 1'b0;
  localparam logic PCLK_RESET_LV = 1'b0;

  typedef enum logic [1:0] {
    RLM_ST_RESET,
    RLM_ST_FREE,
    RLM_ST_SEEK,
    RLM_ST_LOCKED
  } rlm_state_t;

  typedef struct packed {
    logic resetN;
    logic lockSelN;
    logic scanSel;
  } rlm_pins_t;

  typedef struct packed {
    logic blockRstN;
    logic tapRstN;
    logic ioEnable;
    logic pclkForceLow;
    logic scanMode;
  } rlm_ctl_t;

  typedef struct packed {
    logic followRef;
    logic useDefaults;
    logic freeRun;
    logic audioFollowVid;
    logic locked;
  } rlm_clk_t;

endpackage : rlm_pkg

// >>> rlm_board.sv
// Purpose: board side model driving reset and lock select pins
// Assumes: hold count scaled down from the long power-up hold
// Notes:   lock select only pulled low once a reference is seen
`timescale 1ns/1ps
`default_nettype none
module rlm_board #(parameter int HOLD = 8) (
  input  wire logic mclk,
  input  wire logic rstReq,
  input  wire logic lockReq,
  input  wire logic refPresent,
  output logic      resetPinN = 1'b0,
  output logic      lockSelN = 1'b1
);
  int cnt_r = 0;
  always @(posedge mclk) begin
    cnt_r <= rstReq ? HOLD : (cnt_r > 0 ? cnt_r - 1 : 0);
    resetPinN <= !(rstReq || cnt_r > 1);
    lockSelN <= !(lockReq && (refPresent || !lockSelN));
  end
endmodule : rlm_board
`default_nettype wire

// >>> rlm_ctrl_sva.sv
// Purpose: port checker for reset and lock mode control
// Assumes: one clock, sync reset
// Notes:   bound below
`timescale 1ns/1ps
`default_nettype none
module rlm_ctrl_chk (
  input wire logic mclk, reset_n, resetPinN, lockSelN, xtal_in, refPresent,
  input wire logic pixel_clk_out_a, pixel_clk_out_a_oe, pixel_clk_out_b_oe, refClk,
  input wire rlm_pkg::rlm_ctl_t ctl,
  input wire rlm_pkg::rlm_clk_t clk,
  input wire rlm_pkg::rlm_state_t state
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  property p_ref; refClk == xtal_in; endproperty
  a_ref: assert property (p_ref) else $error("ref clock differs from crystal");
  property p_aud; clk.audioFollowVid; endproperty
  a_aud: assert property (p_aud) else $error("audio not following video");
  property p_pin; ctl.pclkForceLow |-> !pixel_clk_out_a && pixel_clk_out_a_oe
    && pixel_clk_out_b_oe; endproperty
  a_pin: assert property (p_pin) else $error("pixel clock not driven low");
  property p_rst; !resetPinN [*3] |-> !ctl.blockRstN; endproperty
  a_rst: assert property (p_rst) else $error("blocks not held in reset");
  property p_io; state == rlm_pkg::RLM_ST_RESET && !ctl.scanMode |-> !ctl.ioEnable;
  endproperty
  a_io: assert property (p_io) else $error("io not floated in reset");
  property p_tap; state == rlm_pkg::RLM_ST_RESET && ctl.scanMode |-> !ctl.tapRstN;
  endproperty
  a_tap: assert property (p_tap) else $error("test sequence not reset");
  property p_rel; resetPinN [*8] |-> ctl.blockRstN; endproperty
  a_rel: assert property (p_rel) else $error("no resume after release");
  property p_lck; clk.locked |-> clk.followRef && state == rlm_pkg::RLM_ST_LOCKED;
  endproperty
  a_lck: assert property (p_lck) else $error("locked flag without lock");
  property p_def; state == rlm_pkg::RLM_ST_SEEK && !$past(refPresent) |-> clk.useDefaults;
  endproperty
  a_def: assert property (p_def) else $error("defaults not used");
  property p_syn; $fell(lockSelN) && $past(lockSelN, 2) && resetPinN
    && state == rlm_pkg::RLM_ST_FREE |=> state == rlm_pkg::RLM_ST_FREE; endproperty
  a_syn: assert property (p_syn) else $error("lock select not synchronised");
endmodule : rlm_ctrl_chk
bind rlm_ctrl rlm_ctrl_chk i_chk (.mclk(mclk), .reset_n(reset_n), .resetPinN(resetPinN),
  .lockSelN(lockSelN), .xtal_in(xtal_in), .refPresent(refPresent), .refClk(refClk),
  .pixel_clk_out_a(pixel_clk_out_a), .pixel_clk_out_a_oe(pixel_clk_out_a_oe),
  .pixel_clk_out_b_oe(pixel_clk_out_b_oe), .ctl(ctl), .clk(clk), .state(state));
`default_nettype wire

// >>> tb_reset_and_lock_mode_control.sv
// Purpose: self-checking bench for reset and lock mode control
// Assumes: board model drives reset and lock select pins
// Notes:   seed fixed at 45
`timescale 1ns/1ps
`default_nettype none
module tb_reset_and_lock_mode_control;
  logic mclk = 0, reset_n = 0, rstReq = 1, lockReq = 0, scanSel = 0, xtal = 0;
  logic refPresent = 0, refLocked = 0, pA = 0, pB = 0;
  logic resetPinN, lockSelN, oA, oeA, oB, oeB, refClk;
  rlm_pkg::rlm_ctl_t ctl;
  rlm_pkg::rlm_clk_t clk;
  rlm_pkg::rlm_state_t state;
  int failures = 0, n_checks = 0;
  always #5 mclk = ~mclk;
  rlm_board i_brd (.mclk(mclk), .rstReq(rstReq), .lockReq(lockReq),
    .refPresent(refPresent), .resetPinN(resetPinN), .lockSelN(lockSelN));
  rlm_ctrl i_dut (.mclk(mclk), .reset_n(reset_n), .resetPinN(resetPinN),
    .lockSelN(lockSelN), .scanSel(scanSel), .xtal_in(xtal), .refPresent(refPresent),
    .refLocked(refLocked), .pixelClkA(pA), .pixelClkB(pB), .pixel_clk_out_a(oA),
    .pixel_clk_out_a_oe(oeA), .pixel_clk_out_b(oB), .pixel_clk_out_b_oe(oeB),
    .refClk(refClk), .ctl(ctl), .clk(clk), .state(state));
  function automatic logic exp_pin(input logic frc, input logic src);
    return frc ? 1'b0 : src;
  endfunction : exp_pin
  task automatic close_out();
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wait_st(input rlm_pkg::rlm_state_t s, input string nm);
    for (int i = 0; i < 64 && state !== s; i++) @(posedge mclk);
    #1 chk(8'(state), 8'(s));
    if (state !== s) close_out();
    else $display("test %s done", nm);
  endtask : wait_st
  initial begin
    void'($urandom(45));
    repeat (6) @(posedge mclk);
    reset_n <= 1'b1;
    rstReq <= 1'b0;
    wait_st(rlm_pkg::RLM_ST_FREE, "release");
    chk(ctl.ioEnable, 8'h01);
    chk(clk.freeRun, 8'h01);
    refPresent <= 1'b1;
    refLocked <= 1'b1;
    lockReq <= 1'b1;
    wait_st(rlm_pkg::RLM_ST_LOCKED, "lock");
    chk(clk.followRef, 8'h01);
    chk(clk.audioFollowVid, 8'h01);
    refPresent <= 1'b0;
    wait_st(rlm_pkg::RLM_ST_SEEK, "lost");
    chk(clk.useDefaults, 8'h01);
    lockReq <= 1'b0;
    wait_st(rlm_pkg::RLM_ST_FREE, "free");
    repeat (200) begin
      @(posedge mclk);
      {pA, pB, xtal, refPresent, refLocked, lockReq} <= 6'($urandom);
      #1 chk(oA, exp_pin(1'b0, pA));
      chk(oB, exp_pin(1'b0, pB));
      chk(refClk, xtal);
    end
    lockReq <= 1'b0;
    rstReq <= 1'b1;
    repeat (4) @(posedge mclk);
    #1 chk({ctl.blockRstN, ctl.ioEnable, oA, oB, oeA, oeB}, 8'h03);
    rstReq <= 1'b0;
    wait_st(rlm_pkg::RLM_ST_FREE, "host reset");
    scanSel <= 1'b1;
    rstReq <= 1'b1;
    repeat (6) @(posedge mclk);
    #1 chk({ctl.tapRstN, ctl.ioEnable, ctl.scanMode}, 8'h03);
    rstReq <= 1'b0;
    wait_st(rlm_pkg::RLM_ST_FREE, "scan reset");
    chk(ctl.tapRstN, 8'h01);
    close_out();
  end
endmodule : tb_reset_and_lock_mode_control
`default_nettype wire
